/* pkg/rcsr_pkg.sv */
// Package with register map, field positions, reset values and carrier types.
package rcsr_pkg;

    localparam logic [7:0] OFS_CTRL_CAUSE = 8'h24;
    localparam logic [7:0] OFS_AHB_RESET = 8'h28;
    localparam logic [7:0] OFS_PLL_DIV = 8'h2c;
    localparam logic [7:0] OFS_KERNEL_SEL = 8'h30;

    localparam int POS_OSC_ON = 0;
    localparam int POS_OSC_STABLE = 1;
    localparam int POS_CORE_RST = 23;
    localparam int POS_CAUSE_CLEAR = 24;
    localparam int POS_OPTION_RST = 25;
    localparam int POS_PIN_RST = 26;
    localparam int POS_POWER_RST = 27;
    localparam int POS_SOFT_RST = 28;
    localparam int POS_IWDG_RST = 29;
    localparam int POS_WWDG_RST = 30;
    localparam int POS_LOWPWR_RST = 31;

    // Writable bit masks per register.
    localparam logic [31:0] MASK_CTRL = 32'h0000_0001;
    localparam logic [31:0] MASK_AHB = 32'h015e_0000;
    localparam logic [31:0] MASK_PLL = 32'h0000_000f;
    localparam logic [31:0] MASK_KSEL = 32'h0000_0153;

    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    localparam logic [7:0] CAUSE_NONE = 8'h00;

    // Wait cycles inserted on a control/status access, alone or right behind another one.
    localparam logic [1:0] CTRL_WAIT_BACK_TO_BACK = 2'h3;
    localparam logic [1:0] CTRL_WAIT_SINGLE = 2'h1;

    // Hardware reset-cause events, one bit per cause, bit 0 is the core domain.
    typedef struct packed {
        logic low_power;
        logic window_watchdog;
        logic independent_watchdog;
        logic software;
        logic power_up_down;
        logic external_pin;
        logic option_load;
        logic core_domain;
    } rcsr_cause_t;

    // Clock configuration driven out to the clock tree.
    typedef struct packed {
        logic slow_internal_osc_on;
        logic [3:0] pll_input_divider;
        logic [1:0] serial_port_kernel_clock_choice;
        logic two_wire_kernel_clock_choice;
        logic consumer_control_clock_choice;
        logic converter_clock_choice;
    } rcsr_clk_cfg_t;

    // Peripheral hold-in-reset outputs.
    typedef struct packed {
        logic touch_ctrl_hold_reset;
        logic port_f_hold_reset;
        logic port_d_hold_reset;
        logic port_c_hold_reset;
        logic port_b_hold_reset;
        logic port_a_hold_reset;
    } rcsr_periph_rst_t;

endpackage

/* logic/rcsr_regs.sv */
// Reset-cause, peripheral reset and kernel clock select registers on AHB-Lite.
// What this block does
// - Bit 0 of control/status switches the slow internal oscillator on or off.
// - Bit 1 reads back whether the slow internal oscillator is stable.
// - System reset clears control bits; cause flags survive until power reset or clear.
// - Writing 1 to bit 24 clears all cause flags; writing 0 does nothing.
// - Bit 23 records a core domain reset, cleared by the clear bit.
// - Bit 25 records an option load reset, cleared by the clear bit.
// - Bit 26 records an external pin reset, cleared by the clear bit.
// - Bit 27 records a power-up or power-down reset, cleared by the clear bit.
// - Bit 28 records a software system reset, cleared by the clear bit.
// - Bit 29 records an independent watchdog reset, cleared by the clear bit.
// - Bit 30 records a window watchdog reset, cleared by the clear bit.
// - Bit 31 records a low-power management reset, cleared by the clear bit.
// - PLL input divider field divides by value plus one.
// - Bits 1:0 of kernel select pick the serial port clock, reset 00.
// - Bit 4 picks the two-wire kernel clock, reset 0.
// - Bit 6 picks the consumer control clock, fast osc/244 or PLL.
// - Control/status takes any width with 1 wait, 3 when back to back.
// - Other three registers take any width with no wait.
//
// Bus timing, as seen from the master.
// A transfer is taken on the rising edge at which hsel, hready and htrans[1] are all high.
// The three fast registers answer with hreadyout high on the next edge, so their data
// phase has no wait state and a write lands on the edge that ends it.
// The control/status register answers after one wait state when reached from idle or from
// another register, and after three when the previous transfer also went to it with no
// idle cycle between; a small counter holds the wait states still to come.
// Read data is captured when the address phase is taken, and the status word is taken
// again on the last wait so that a flag raised during the waits is not missed.
// Unmapped offsets read zero, ignore writes and still answer OKAY.
//
// Reset domains.
// The system reset clears the bus state, the enable bit and every configuration field.
// The reset-cause flags sit on their own power-reset input and are untouched by the
// system reset, so software can still read why the part restarted.
// Whoever drives the cause inputs pulses the power-up event after power reset.
//
// Limitations.
// The ready flag is registered once, so it follows the oscillator one cycle late.
// The converter clock choice bit stays writable; software is expected to leave it at zero.
// There is no interrupt output; software polls the flags.
//
// Local design decision: the AHB-Lite register port.
module rcsr_regs (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic power_reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic slow_internal_osc_stable,
    input wire rcsr_pkg::rcsr_cause_t cause_event,
    output rcsr_pkg::rcsr_clk_cfg_t clk_cfg,
    output rcsr_pkg::rcsr_periph_rst_t periph_rst
);
    import rcsr_pkg::*;

    // State that system reset clears, except ready, which it raises; stable_q is kept apart.
    // Bus phase, wait counter, read data and the four registers.
    typedef struct packed {
        logic dphase;
        logic dwrite;
        logic [7:0] daddr;
        logic [3:0] dbe;
        logic [1:0] wait_cnt;
        logic last_was_ctrl;
        logic [31:0] rdata;
        logic rdy;
        logic [31:0] ctrl;
        logic [31:0] ahb;
        logic [31:0] pll;
        logic [31:0] ksel;
    } rcsr_state_t;

    rcsr_state_t s_q;
    rcsr_state_t s_d;
    // Cause flags live on the power-reset domain only.
    logic [7:0] cause_q;
    logic [7:0] cause_d;
    logic stable_q;

    logic addr_take;
    logic [3:0] be;
    logic [31:0] wmask;
    logic [31:0] ctrl_read;
    logic clear_req;

    // Address phase is taken when selected, ready and the transfer is not idle or busy.
    assign addr_take = hsel && hready && htrans[1];

    // Byte lanes from size and low address bits.
    // Halfword and byte accesses touch only their own lanes; reserved bits drop out later.
    always_comb begin
        be = 4'h0;
        unique case (hsize)
            3'h0: be = 4'h1 << haddr[1:0];
            3'h1: be = haddr[1] ? 4'hc : 4'h3;
            default: be = 4'hf;
        endcase
    end

    // Per-bit write mask built from the lanes latched in the address phase.
    assign wmask = {{8{s_q.dbe[3]}}, {8{s_q.dbe[2]}}, {8{s_q.dbe[1]}}, {8{s_q.dbe[0]}}};
    // Clear takes effect when its lane is written with a one.
    assign clear_req = s_q.dphase && s_q.dwrite && (s_q.wait_cnt == 2'h0)
        && (s_q.daddr == OFS_CTRL_CAUSE) && s_q.dbe[3] && hwdata[POS_CAUSE_CLEAR];

    // Status readback composes the oscillator state and the cause flags.
    assign ctrl_read = {cause_q[7:1], 1'b0, cause_q[0], 21'h0, stable_q,
        s_q.ctrl[POS_OSC_ON]};

    // Bus and register next-state logic.
    // The data phase counts down its waits, then ends and lands a pending write.
    // A new address phase may be taken on the same edge that ends the old data phase,
    // which is what makes two status accesses in a row back to back.
    always_comb begin
        s_d = s_q;
        if (s_q.dphase && s_q.wait_cnt != 2'h0) begin
            s_d.wait_cnt = s_q.wait_cnt - 2'h1;
        end else if (s_q.dphase) begin
            s_d.dphase = 1'b0;
            s_d.rdy = 1'b1;
            if (s_q.dwrite) begin
                unique case (s_q.daddr)
                    OFS_CTRL_CAUSE: s_d.ctrl = (s_q.ctrl & ~(wmask & MASK_CTRL))
                        | (hwdata & wmask & MASK_CTRL);
                    OFS_AHB_RESET: s_d.ahb = (s_q.ahb & ~(wmask & MASK_AHB))
                        | (hwdata & wmask & MASK_AHB);
                    OFS_PLL_DIV: s_d.pll = (s_q.pll & ~(wmask & MASK_PLL))
                        | (hwdata & wmask & MASK_PLL);
                    OFS_KERNEL_SEL: s_d.ksel = (s_q.ksel & ~(wmask & MASK_KSEL))
                        | (hwdata & wmask & MASK_KSEL);
                    default: ;
                endcase
            end
        end
        if (addr_take && s_d.rdy) begin
            s_d.dphase = 1'b1;
            s_d.dwrite = hwrite;
            s_d.daddr = {haddr[7:2], 2'b00};
            s_d.dbe = be;
            s_d.last_was_ctrl = ({haddr[7:2], 2'b00} == OFS_CTRL_CAUSE);
            if ({haddr[7:2], 2'b00} == OFS_CTRL_CAUSE) begin
                s_d.wait_cnt = s_q.last_was_ctrl ? CTRL_WAIT_BACK_TO_BACK
                    : CTRL_WAIT_SINGLE;
                s_d.rdy = 1'b0;
            end else begin
                s_d.wait_cnt = 2'h0;
                s_d.rdy = 1'b1;
            end
            unique case ({haddr[7:2], 2'b00})
                OFS_CTRL_CAUSE: s_d.rdata = ctrl_read;
                OFS_AHB_RESET: s_d.rdata = s_q.ahb;
                OFS_PLL_DIV: s_d.rdata = s_q.pll;
                OFS_KERNEL_SEL: s_d.rdata = s_q.ksel;
                default: s_d.rdata = RESET_ZERO;
            endcase
        end else if (!addr_take && !s_d.dphase) begin
            s_d.last_was_ctrl = 1'b0;
        end
        // Refresh status data on the last wait so the freshest flags are returned.
        if (s_q.dphase && s_q.wait_cnt == 2'h1 && s_q.daddr == OFS_CTRL_CAUSE) begin
            s_d.rdata = ctrl_read;
            s_d.rdy = 1'b1;
        end
    end

    // System reset clears all non-flag state.
    // Ready output comes up high so the bus is never stalled out of reset.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_q <= '{rdy: 1'b1, default: '0};
            stable_q <= 1'b0;
        end else begin
            s_q <= s_d;
            stable_q <= slow_internal_osc_stable;
        end
    end

    // Cause flags: a new event wins over a clear in the same cycle.
    // A clear meeting an event drops the older flags but keeps the new one.
    always_comb begin
        cause_d = cause_q;
        if (clear_req) begin
            cause_d = CAUSE_NONE;
        end
        cause_d = cause_d | cause_event;
    end

    // Of the two resets only power reset clears the flags; the power-up event is then pulsed from outside.
    always_ff @(posedge clk_sys) begin
        if (!power_reset_n) begin
            cause_q <= CAUSE_NONE;
        end else begin
            cause_q <= cause_d;
        end
    end

    // Outputs straight from flip-flops.
    // Nothing combinational sits between the register state and the pins.
    assign hreadyout = s_q.rdy;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign clk_cfg = '{slow_internal_osc_on: s_q.ctrl[POS_OSC_ON],
        pll_input_divider: s_q.pll[3:0],
        serial_port_kernel_clock_choice: s_q.ksel[1:0],
        two_wire_kernel_clock_choice: s_q.ksel[4],
        consumer_control_clock_choice: s_q.ksel[6],
        converter_clock_choice: s_q.ksel[8]};
    // Hold-in-reset outputs, one register bit per peripheral.
    assign periph_rst = '{touch_ctrl_hold_reset: s_q.ahb[24],
        port_f_hold_reset: s_q.ahb[22],
        port_d_hold_reset: s_q.ahb[20],
        port_c_hold_reset: s_q.ahb[19],
        port_b_hold_reset: s_q.ahb[18],
        port_a_hold_reset: s_q.ahb[17]};

    // Checks. Flag checks run on the power-reset domain, because a system reset must
    // leave the flags alone; bus and configuration checks run on the system-reset domain.
    //
    // Named steps that several properties share.
    // A clear write that meets no new event in the same cycle.
    sequence clear_write;
        clear_req && cause_event == CAUSE_NONE;
    endsequence
    // A clear write that meets a new event in the same cycle.
    sequence clear_meets_event;
        clear_req && cause_event != CAUSE_NONE;
    endsequence
    // A status address phase taken after idle or after another register.
    sequence ctrl_take_from_idle;
        addr_take && haddr[7:2] == OFS_CTRL_CAUSE[7:2] && !s_q.last_was_ctrl;
    endsequence
    // A status address phase taken right behind another status access.
    sequence ctrl_take_back_to_back;
        addr_take && haddr[7:2] == OFS_CTRL_CAUSE[7:2] && s_q.last_was_ctrl;
    endsequence
    // An address phase to any register other than control/status.
    sequence fast_take;
        addr_take && haddr[7:2] != OFS_CTRL_CAUSE[7:2];
    endsequence
    // The last data-phase cycle of a status write that covers lane 0.
    sequence ctrl_write_lane0_end;
        s_q.dphase && s_q.dwrite && s_q.daddr == OFS_CTRL_CAUSE && s_q.wait_cnt == 2'h0
            && s_q.dbe[0];
    endsequence
    // Word writes to each fast register.
    sequence ahb_word_write;
        addr_take && hwrite && hsize == 3'h2 && haddr[7:2] == OFS_AHB_RESET[7:2];
    endsequence
    sequence pll_word_write;
        addr_take && hwrite && hsize == 3'h2 && haddr[7:2] == OFS_PLL_DIV[7:2];
    endsequence
    sequence ksel_word_write;
        addr_take && hwrite && hsize == 3'h2 && haddr[7:2] == OFS_KERNEL_SEL[7:2];
    endsequence
    // A read beyond the last register.
    sequence unmapped_read;
        addr_take && !hwrite && haddr[7:2] > OFS_KERNEL_SEL[7:2];
    endsequence

    // A clear with no competing event empties every flag.
    chk_clear_all_flags: assert property (@(posedge clk_sys) disable iff (!power_reset_n)
        clear_write |=> cause_q == CAUSE_NONE) else $error("flags not cleared");
    // An event in the same cycle as a clear is still recorded.
    chk_set_beats_clr: assert property (@(posedge clk_sys) disable iff (!power_reset_n)
        clear_meets_event |=> (cause_q & $past(cause_event)) == $past(cause_event))
        else $error("event lost to a clear");

    // Each hardware event raises its own flag in the status word on the next edge.
    chk_event_sets_flag: assert property (@(posedge clk_sys) disable iff (!power_reset_n)
        cause_event[0] |=> cause_q[0]) else $error("core flag lost");
    chk_option_flag: assert property (@(posedge clk_sys) disable iff (!power_reset_n)
        cause_event[1] |=> ctrl_read[POS_OPTION_RST]) else $error("option flag lost");
    chk_pin_flag_sets: assert property (@(posedge clk_sys) disable iff (!power_reset_n)
        cause_event[2] |=> ctrl_read[POS_PIN_RST]) else $error("pin flag lost");
    chk_power_flag: assert property (@(posedge clk_sys) disable iff (!power_reset_n)
        cause_event[3] |=> ctrl_read[POS_POWER_RST]) else $error("power flag lost");
    chk_soft_flag: assert property (@(posedge clk_sys) disable iff (!power_reset_n)
        cause_event[4] |=> ctrl_read[POS_SOFT_RST]) else $error("software flag lost");
    chk_iwdg_flag: assert property (@(posedge clk_sys) disable iff (!power_reset_n)
        cause_event[5] |=> ctrl_read[POS_IWDG_RST]) else $error("watchdog flag lost");
    chk_wwdg_flag: assert property (@(posedge clk_sys) disable iff (!power_reset_n)
        cause_event[6] |=> ctrl_read[POS_WWDG_RST]) else $error("window flag lost");
    chk_lowpwr_flag: assert property (@(posedge clk_sys) disable iff (!power_reset_n)
        cause_event[7] |=> ctrl_read[POS_LOWPWR_RST]) else $error("low power flag lost");

    // A system reset with no clear keeps every flag and adds new events.
    chk_flags_hold: assert property (@(posedge clk_sys) disable iff (!power_reset_n)
        !clear_req && !reset_n |=> cause_q == ($past(cause_q) | $past(cause_event)))
        else $error("flags lost on system reset");
    // System reset clears the enable bit, every configuration field and the read data, and raises ready.
    chk_sys_reset_clr: assert property (@(posedge clk_sys)
        !reset_n |=> clk_cfg == '0 && periph_rst == '0 && hreadyout && hrdata == RESET_ZERO)
        else $error("state kept over system reset");

    // The enable output mirrors its register bit.
    chk_osc_on_out: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_cfg.slow_internal_osc_on == s_q.ctrl[POS_OSC_ON]) else $error("osc enable");
    // A status write on lane 0 moves the enable bit to the written value.
    chk_osc_on_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ctrl_write_lane0_end |=> clk_cfg.slow_internal_osc_on == $past(hwdata[POS_OSC_ON]))
        else $error("enable write lost");
    // The ready bit follows the oscillator input one cycle late.
    chk_ready_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $past(reset_n) |-> ctrl_read[POS_OSC_STABLE] == $past(slow_internal_osc_stable))
        else $error("ready flag stale");

    // The divider register answers without a wait state.
    chk_fast_regs: assert property (@(posedge clk_sys) disable iff (!reset_n)
        addr_take && hready && haddr[7:0] == OFS_PLL_DIV |=> hreadyout)
        else $error("wait on fast register");
    // Every register but control/status answers without a wait state.
    chk_fast_no_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fast_take |=> hreadyout) else $error("wait on a fast register");
    // A status access waits between one and three cycles.
    chk_ctrl_waits: assert property (@(posedge clk_sys) disable iff (!reset_n)
        addr_take && hready && haddr[7:0] == OFS_CTRL_CAUSE |=> !hreadyout ##[1:3] hreadyout)
        else $error("status wait out of range");
    // From idle a status access waits exactly one cycle.
    chk_ctrl_one_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ctrl_take_from_idle |=> !hreadyout ##1 hreadyout)
        else $error("status access not one wait");
    // Back to back a status access waits exactly three cycles.
    chk_ctrl_three_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ctrl_take_back_to_back |=> !hreadyout [*3] ##1 hreadyout)
        else $error("status access not three waits");
    // The response is always OKAY.
    chk_resp_okay: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !hresp) else $error("error response");

    // A word write to a fast register shows on the outputs one edge after its data phase.
    chk_port_hold_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ahb_word_write ##1 hreadyout |=> periph_rst.port_a_hold_reset == $past(hwdata[17])
            && periph_rst.touch_ctrl_hold_reset == $past(hwdata[24]))
        else $error("hold reset write lost");
    chk_divider_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pll_word_write ##1 hreadyout |=> clk_cfg.pll_input_divider == $past(hwdata[3:0]))
        else $error("divider write lost");
    chk_serial_sel: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ksel_word_write ##1 hreadyout
            |=> clk_cfg.serial_port_kernel_clock_choice == $past(hwdata[1:0]))
        else $error("serial clock choice lost");
    chk_two_wire_sel: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ksel_word_write ##1 hreadyout
            |=> clk_cfg.two_wire_kernel_clock_choice == $past(hwdata[4]))
        else $error("two-wire clock choice lost");
    chk_consumer_sel: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ksel_word_write ##1 hreadyout
            |=> clk_cfg.consumer_control_clock_choice == $past(hwdata[6]))
        else $error("consumer clock choice lost");

    // Reads beyond the last register return zero.
    chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        unmapped_read |=> hrdata == RESET_ZERO) else $error("unmapped read not zero");
    // Reserved bits of the peripheral reset and kernel select registers never hold a one.
    chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_q.ahb & ~MASK_AHB) == 32'h0000_0000 && (s_q.ksel & ~MASK_KSEL) == 32'h0000_0000)
        else $error("reserved bit set");
endmodule

/* tb/rcsr_tb.sv */
// Self-checking bench for the reset-cause, peripheral reset and clock select registers.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rcsr_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic power_reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic osc_stable = 1'b0;
    rcsr_cause_t cause_event = '0;
    rcsr_clk_cfg_t clk_cfg;
    rcsr_periph_rst_t periph_rst;
    int fail_count = 0;
    int checks_done = 0;
    int seed = 32'h2ab8_05bb;
    int waits = 0;
    logic [31:0] rd;
    logic [31:0] wv;
    logic [7:0] regs [4] = '{OFS_CTRL_CAUSE, OFS_AHB_RESET, OFS_PLL_DIV, OFS_KERNEL_SEL};
    logic [31:0] masks [4] = '{MASK_CTRL, MASK_AHB, MASK_PLL, MASK_KSEL};
    int pos [8] = '{POS_CORE_RST, POS_OPTION_RST, POS_PIN_RST, POS_POWER_RST, POS_SOFT_RST,
        POS_IWDG_RST, POS_WWDG_RST, POS_LOWPWR_RST};
    // Half period of 5 ns gives the 100 MHz system clock.
    always #5 clk_sys = ~clk_sys;
    // The single slave's ready output is the bus ready.
    rcsr_regs DUT (.clk_sys(clk_sys), .reset_n(reset_n), .power_reset_n(power_reset_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .slow_internal_osc_stable(osc_stable), .cause_event(cause_event),
        .clk_cfg(clk_cfg), .periph_rst(periph_rst));
    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Compares one value and reports a difference at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // One single AHB-Lite transfer; waits counts data-phase stall cycles, rd takes read data.
    task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] sz,
        input logic [31:0] wd);
        int n = 0;
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= sz;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waits = 0;
        do begin
            @(posedge clk_sys);
            if (hreadyout !== 1'b1) begin
                waits++;
            end
        end while (hreadyout !== 1'b1 && waits < 50);
        rd = hrdata;
        if (n >= 50 || waits >= 50) begin
            fail_count++;
            $display("mismatch at %0t: bus transfer never completed", $time);
            end_sim();
        end
    endtask
    // Pulses one reset-cause event for a single cycle.
    task automatic pulse(input int i);
        @(posedge clk_sys);
        cause_event <= rcsr_cause_t'(8'h01 << i);
        @(posedge clk_sys);
        cause_event <= '0;
    endtask
    // Main sequence: reset values, read-back, flags, resets, unmapped access.
    initial begin
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        power_reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            xfer({24'h00_0000, regs[i]}, 1'b0, 3'h2, 32'h0000_0000);
            chk(rd, 32'h0000_0000, "reset value");
        end
        repeat (5) for (int i = 1; i < 4; i++) begin
            wv = $random(seed);
            if (i == 3) begin
                wv[8] = 1'b0;
            end
            xfer({24'h00_0000, regs[i]}, 1'b1, 3'h2, wv);
            xfer({24'h00_0000, regs[i]}, 1'b0, 3'h2, 32'h0000_0000);
            chk(rd, wv & masks[i], "read back");
            chk(waits, 0, "fast register wait");
        end
        xfer({24'h00_0000, OFS_AHB_RESET}, 1'b1, 3'h2, 32'hffff_ffff);
        xfer({24'h00_0000, OFS_KERNEL_SEL}, 1'b1, 3'h2, 32'hffff_feff);
        xfer({24'h00_0000, OFS_PLL_DIV}, 1'b1, 3'h2, 32'hffff_ffff);
        xfer({24'h00_0000, OFS_PLL_DIV}, 1'b0, 3'h2, 32'h0000_0000);
        chk(32'(periph_rst), 32'h0000_003f, "hold reset outputs");
        chk(32'(clk_cfg), 32'h0000_01fe, "clock outputs");
        osc_stable <= 1'b1;
        xfer({24'h00_0000, OFS_CTRL_CAUSE}, 1'b1, 3'h2, 32'hfeff_ffff);
        xfer({24'h00_0000, OFS_CTRL_CAUSE}, 1'b0, 3'h2, 32'h0000_0000);
        chk(rd, 32'h0000_0003, "enable and ready");
        chk(waits, 32'(CTRL_WAIT_SINGLE), "status wait");
        chk(clk_cfg.slow_internal_osc_on, 32'h0000_0001, "oscillator on");
        osc_stable <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            pulse(i);
            xfer({24'h00_0000, OFS_CTRL_CAUSE}, 1'b1, 3'h2, 32'h0000_0001);
            xfer({24'h00_0000, OFS_CTRL_CAUSE}, 1'b0, 3'h2, 32'h0000_0000);
            chk(rd, 32'h0000_0001 | (32'h1 << pos[i]), "cause flag");
            xfer({24'h00_0000, OFS_CTRL_CAUSE} + 32'h3, 1'b1, 3'h0, 32'h0100_0000);
            xfer({24'h00_0000, OFS_CTRL_CAUSE}, 1'b0, 3'h2, 32'h0000_0000);
            chk(rd, 32'h0000_0001, "flag clear");
        end
        pulse(2);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        xfer({24'h00_0000, OFS_CTRL_CAUSE}, 1'b0, 3'h2, 32'h0000_0000);
        chk(rd, 32'h1 << POS_PIN_RST, "flag kept over system reset");
        chk({periph_rst, clk_cfg}, 32'h0000_0000, "outputs after reset");
        power_reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        power_reset_n <= 1'b1;
        xfer({24'h00_0000, OFS_CTRL_CAUSE}, 1'b0, 3'h2, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "flags after power reset");
        xfer(32'h0000_0040, 1'b1, 3'h2, $random(seed));
        xfer(32'h0000_0040, 1'b0, 3'h2, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "unmapped read");
        chk(hresp, 32'h0000_0000, "response okay");
        end_sim();
    end
endmodule
